// File: iemb_mask_bank.sv
`timescale 1ns/100ps
`default_nettype none

module iemb_mask_bank
  import iemb_pkg::*;
(
  // clock, reset, enable
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  // sfr byte port from the core
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [3:0]          sfr_page,
  input  wire logic                sfr_wr,
  input  wire logic                sfr_rd,
  input  wire logic [7:0]          sfr_wdata,
  // sfr bit port from the core
  input  wire logic [7:0]          bit_addr,
  input  wire logic                bit_wr,
  input  wire logic                bit_rd,
  input  wire logic                bit_wdata,
  // peripheral flags
  input  wire iemb_flags_t         src_flags,
  // read answers
  output logic [7:0]               sfr_rdata_q,
  output logic                     sfr_hit_q,
  output logic                     bit_rdata_q,
  output logic                     bit_hit_q,
  // gated requests to the core, index is the vector number
  output logic [NUM_SRC-1:0]       irq_req_q,
  output logic                     irq_any_q,
  // raw combined sources, for status and wake-up logic
  output logic [NUM_SRC-1:0]       src_pend_q
);

  // enable registers
  logic [7:0]         ie_main_q;
  logic [7:0]         ie_exta_q;
  logic [7:0]         ie_extb_q;

  // decode
  logic               hit_main;
  logic               hit_exta;
  logic               hit_extb;
  logic               bit_hit_main;
  logic [2:0]         bit_sel;

  // combined sources and matching enables
  logic [NUM_SRC-1:0] src_raw;
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] req_d;
  logic               global_irq_gate;

  // named enable fields
  logic               converter_irq_en;
  logic               brownout_irq_en;
  logic               uart0_irq_en;
  logic               timer1_irq_en;
  logic               ext_pin1_irq_en;
  logic               timer0_irq_en;
  logic               ext_pin0_irq_en;
  logic               timer2_irq_en;
  logic               spi_irq_en;
  logic               fault_brake_irq_en;
  logic               watchdog_irq_en;
  logic               pwm_unit0_irq_en;
  logic               capture_irq_en;
  logic               pin_change_irq_en;
  logic               two_wire_irq_en;
  logic               pwm_unit3_irq_en;
  logic               pwm_unit2_irq_en;
  logic               pwm_unit1_irq_en;
  logic               wakeup_timer_irq_en;
  logic               timer3_irq_en;
  logic               uart1_irq_en;

  // main register ignores the page, extended ones live on page 0 only
  assign hit_main     = (sfr_addr == IE_MAIN_ADDR);
  assign hit_exta     = (sfr_addr == IE_EXTA_ADDR) && (sfr_page == EXT_PAGE);
  assign hit_extb     = (sfr_addr == IE_EXTB_ADDR) && (sfr_page == EXT_PAGE);

  // only the main register is bit addressable: bit addresses a8..af
  assign bit_hit_main = (bit_addr[7:3] == IE_MAIN_ADDR[7:3]);
  assign bit_sel      = bit_addr[2:0];

  // field views of the main register
  assign global_irq_gate  = ie_main_q[POS_GLOBAL];
  assign converter_irq_en = ie_main_q[POS_CONV];
  assign brownout_irq_en  = ie_main_q[POS_BROWN];
  assign uart0_irq_en     = ie_main_q[POS_UART0];
  assign timer1_irq_en    = ie_main_q[POS_TMR1];
  assign ext_pin1_irq_en  = ie_main_q[POS_EXT1];
  assign timer0_irq_en    = ie_main_q[POS_TMR0];
  assign ext_pin0_irq_en  = ie_main_q[POS_EXT0];

  // field views of the first extended register
  assign timer2_irq_en      = ie_exta_q[POS_TMR2];
  assign spi_irq_en         = ie_exta_q[POS_SPI];
  assign fault_brake_irq_en = ie_exta_q[POS_BRAKE];
  assign watchdog_irq_en    = ie_exta_q[POS_WDOG];
  assign pwm_unit0_irq_en   = ie_exta_q[POS_PWM0];
  assign capture_irq_en     = ie_exta_q[POS_CAPT];
  assign pin_change_irq_en  = ie_exta_q[POS_PINCHG];
  assign two_wire_irq_en    = ie_exta_q[POS_TWI];

  // field views of the second extended register
  assign pwm_unit3_irq_en    = ie_extb_q[POS_PWM3];
  assign pwm_unit2_irq_en    = ie_extb_q[POS_PWM2];
  assign pwm_unit1_irq_en    = ie_extb_q[POS_PWM1];
  assign wakeup_timer_irq_en = ie_extb_q[POS_WKT];
  assign timer3_irq_en       = ie_extb_q[POS_TMR3];
  assign uart1_irq_en        = ie_extb_q[POS_UART1];

  // main enable register, the only one reachable by bit writes
  iemb_en_reg #(
    .RST_VAL  (IE_MAIN_RST),
    .WR_MASK  (8'hff)
  ) u_main_reg (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .byte_we  (sfr_wr && hit_main),
    .byte_val (sfr_wdata),
    .bit_we   (bit_wr && bit_hit_main),
    .bit_idx  (bit_sel),
    .bit_val  (bit_wdata),
    .reg_q    (ie_main_q)
  );

  // first extended register, all eight bits writable, no bit access
  iemb_en_reg #(
    .RST_VAL  (IE_EXTA_RST),
    .WR_MASK  (8'hff)
  ) u_exta_reg (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .byte_we  (sfr_wr && hit_exta),
    .byte_val (sfr_wdata),
    .bit_we   (1'b0),
    .bit_idx  (3'h0),
    .bit_val  (1'b0),
    .reg_q    (ie_exta_q)
  );

  // second extended register, top two bits held at zero
  iemb_en_reg #(
    .RST_VAL  (IE_EXTB_RST),
    .WR_MASK  (IE_EXTB_MASK)
  ) u_extb_reg (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .byte_we  (sfr_wr && hit_extb),
    .byte_val (sfr_wdata),
    .bit_we   (1'b0),
    .bit_idx  (3'h0),
    .bit_val  (1'b0),
    .reg_q    (ie_extb_q)
  );

  // combine each peripheral's flags into one source line.
  // flags are levels held by the peripherals until cleared, so a source
  // raised while gated is simply seen again once the gate opens
  always_comb begin
    src_raw     = '0;
    src_raw[0]  = src_flags.ext_irq_pin_a;
    src_raw[1]  = src_flags.timer0_overflow_flag;
    src_raw[2]  = src_flags.ext_irq_pin_b;
    src_raw[3]  = src_flags.timer1_overflow_flag;
    src_raw[4]  = src_flags.uart0_tx_done_flag
                | src_flags.uart0_rx_done_flag;
    src_raw[5]  = src_flags.timer2_event_flag;
    src_raw[6]  = src_flags.two_wire_status_flag
                | src_flags.two_wire_timeout_flag;
    src_raw[7]  = |src_flags.pin_change_flags;
    src_raw[8]  = src_flags.brownout_flag;
    src_raw[9]  = src_flags.spi_done_flag
                | src_flags.spi_overrun_flag
                | src_flags.spi_mode_fault_flag;
    src_raw[10] = src_flags.watchdog_flag;
    src_raw[11] = src_flags.converter_done_flag;
    src_raw[12] = |src_flags.capture_channel_flags;
    src_raw[13] = src_flags.pwm_unit0_period_flag;
    src_raw[14] = src_flags.fault_brake_flag;
    src_raw[15] = src_flags.uart1_tx_done_flag
                | src_flags.uart1_rx_done_flag;
    src_raw[16] = src_flags.timer3_overflow_flag;
    src_raw[17] = src_flags.wakeup_timer_flag;
    src_raw[18] = src_flags.pwm_unit1_period_flag;
    src_raw[19] = src_flags.pwm_unit2_period_flag;
    src_raw[20] = src_flags.pwm_unit3_period_flag;
  end

  // line up each source with its own enable bit
  always_comb begin
    src_en     = '0;
    src_en[0]  = ext_pin0_irq_en;
    src_en[1]  = timer0_irq_en;
    src_en[2]  = ext_pin1_irq_en;
    src_en[3]  = timer1_irq_en;
    src_en[4]  = uart0_irq_en;
    src_en[5]  = timer2_irq_en;
    src_en[6]  = two_wire_irq_en;
    src_en[7]  = pin_change_irq_en;
    src_en[8]  = brownout_irq_en;
    src_en[9]  = spi_irq_en;
    src_en[10] = watchdog_irq_en;
    src_en[11] = converter_irq_en;
    src_en[12] = capture_irq_en;
    src_en[13] = pwm_unit0_irq_en;
    src_en[14] = fault_brake_irq_en;
    src_en[15] = uart1_irq_en;
    src_en[16] = timer3_irq_en;
    src_en[17] = wakeup_timer_irq_en;
    src_en[18] = pwm_unit1_irq_en;
    src_en[19] = pwm_unit2_irq_en;
    src_en[20] = pwm_unit3_irq_en;
  end

  // no distinction by who set the flag: only its level counts
  assign req_d = src_raw & src_en & {NUM_SRC{global_irq_gate}};

  // registered requests; one cycle of latency buys a clean flop output
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_req_q <= '0;
      irq_any_q <= 1'b0;
    end else if (clk_en) begin
      irq_req_q <= req_d;
      irq_any_q <= |req_d;
    end
  end

  // raw source state, ungated, so the core can see what is waiting
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      src_pend_q <= '0;
    end else if (clk_en) begin
      src_pend_q <= src_raw;
    end
  end

  // byte read answer, unmapped addresses answer zero with no hit
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q   <= 1'b0;
    end else if (clk_en) begin
      if (sfr_rd && hit_main) begin
        sfr_rdata_q <= ie_main_q;
        sfr_hit_q   <= 1'b1;
      end else if (sfr_rd && hit_exta) begin
        sfr_rdata_q <= ie_exta_q;
        sfr_hit_q   <= 1'b1;
      end else if (sfr_rd && hit_extb) begin
        sfr_rdata_q <= ie_extb_q & IE_EXTB_MASK;
        sfr_hit_q   <= 1'b1;
      end else begin
        sfr_rdata_q <= 8'h00;
        sfr_hit_q   <= 1'b0;
      end
    end
  end

  // bit read answer for the bit-addressable main register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bit_rdata_q <= 1'b0;
      bit_hit_q   <= 1'b0;
    end else if (clk_en) begin
      if (bit_rd && bit_hit_main) begin
        bit_rdata_q <= ie_main_q[bit_sel];
        bit_hit_q   <= 1'b1;
      end else begin
        bit_rdata_q <= 1'b0;
        bit_hit_q   <= 1'b0;
      end
    end
  end

endmodule : iemb_mask_bank

// one enable register: byte write, optional bit write; bits outside the
// write mask never leave zero, so they read back as zero
module iemb_en_reg
  import iemb_pkg::*;
#(
  parameter logic [7:0] RST_VAL = IE_MAIN_RST,
  parameter logic [7:0] WR_MASK = 8'hff
)
(
  // clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  // byte write
  input  wire logic       byte_we,
  input  wire logic [7:0] byte_val,
  // bit write, held low where the register is not bit addressable
  input  wire logic       bit_we,
  input  wire logic [2:0] bit_idx,
  input  wire logic       bit_val,
  // register contents
  output logic [7:0]      reg_q
);

  // byte write wins over a bit write in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_q <= RST_VAL & WR_MASK;
    end else if (clk_en) begin
      if (byte_we) begin
        reg_q <= byte_val & WR_MASK;
      end else if (bit_we) begin
        reg_q[bit_idx] <= bit_val & WR_MASK[bit_idx];
      end
    end
  end

endmodule : iemb_en_reg
`default_nettype wire

// File: iemb_pkg.sv
`default_nettype none
package iemb_pkg;

  // sfr addresses of the three enable registers
  localparam logic [7:0] IE_MAIN_ADDR  = 8'ha8;
  localparam logic [7:0] IE_EXTA_ADDR  = 8'h9b;
  localparam logic [7:0] IE_EXTB_ADDR  = 8'h9c;

  // reset values
  localparam logic [7:0] IE_MAIN_RST   = 8'h00;
  localparam logic [7:0] IE_EXTA_RST   = 8'h00;
  localparam logic [7:0] IE_EXTB_RST   = 8'h00;

  // writable bits of the second extended register
  localparam logic [7:0] IE_EXTB_MASK  = 8'h3f;

  // page that holds the extended registers
  localparam logic [3:0] EXT_PAGE      = 4'h0;

  // field positions in irq_enable_main
  localparam int unsigned POS_GLOBAL   = 7;
  localparam int unsigned POS_CONV     = 6;
  localparam int unsigned POS_BROWN    = 5;
  localparam int unsigned POS_UART0    = 4;
  localparam int unsigned POS_TMR1     = 3;
  localparam int unsigned POS_EXT1     = 2;
  localparam int unsigned POS_TMR0     = 1;
  localparam int unsigned POS_EXT0     = 0;

  // field positions in extra_irq_mask_a
  localparam int unsigned POS_TMR2     = 7;
  localparam int unsigned POS_SPI      = 6;
  localparam int unsigned POS_BRAKE    = 5;
  localparam int unsigned POS_WDOG     = 4;
  localparam int unsigned POS_PWM0     = 3;
  localparam int unsigned POS_CAPT     = 2;
  localparam int unsigned POS_PINCHG   = 1;
  localparam int unsigned POS_TWI      = 0;

  // field positions in extra_irq_mask_b
  localparam int unsigned POS_PWM3     = 5;
  localparam int unsigned POS_PWM2     = 4;
  localparam int unsigned POS_PWM1     = 3;
  localparam int unsigned POS_WKT      = 2;
  localparam int unsigned POS_TMR3     = 1;
  localparam int unsigned POS_UART1    = 0;

  // request index, equal to the core's vector number
  localparam int unsigned NUM_SRC      = 21;

  // raw source flags as the peripherals hold them
  typedef struct packed {
    logic       ext_irq_pin_a;
    logic       ext_irq_pin_b;
    logic       timer0_overflow_flag;
    logic       timer1_overflow_flag;
    logic       timer2_event_flag;
    logic       timer3_overflow_flag;
    logic       uart0_tx_done_flag;
    logic       uart0_rx_done_flag;
    logic       uart1_tx_done_flag;
    logic       uart1_rx_done_flag;
    logic       converter_done_flag;
    logic       brownout_flag;
    logic       spi_done_flag;
    logic       spi_overrun_flag;
    logic       spi_mode_fault_flag;
    logic       fault_brake_flag;
    logic       watchdog_flag;
    logic       pwm_unit0_period_flag;
    logic       pwm_unit1_period_flag;
    logic       pwm_unit2_period_flag;
    logic       pwm_unit3_period_flag;
    logic [2:0] capture_channel_flags;
    logic [7:0] pin_change_flags;
    logic       two_wire_status_flag;
    logic       two_wire_timeout_flag;
    logic       wakeup_timer_flag;
  } iemb_flags_t;

endpackage : iemb_pkg
`default_nettype wire

// File: iemb_flag_src.sv
`timescale 1ns/100ps
`default_nettype none
module iemb_flag_src
  import iemb_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // flag load from the bench, standing for hardware or software setting a flag
  input  wire logic        load,
  input  wire logic [34:0] load_val,
  // flag levels toward the block
  output iemb_flags_t      flags_q
);
  // flags are held levels: set alike by hardware or software, kept until cleared
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= '0;
    end else if (load) begin
      flags_q <= iemb_flags_t'(load_val);
    end
  end
endmodule : iemb_flag_src
`default_nettype wire

// File: iemb_mask_bank_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module iemb_mask_bank_chk
  import iemb_pkg::*;
(
  // clock, reset and enable
  input wire logic                ref_clk,
  input wire logic                resetn,
  input wire logic                clk_en,
  // register ports
  input wire logic [7:0]          sfr_addr,
  input wire logic [3:0]          sfr_page,
  input wire logic                sfr_wr,
  input wire logic                sfr_rd,
  input wire logic [7:0]          sfr_wdata,
  input wire logic [7:0]          bit_addr,
  input wire logic                bit_wr,
  input wire logic                bit_rd,
  input wire logic                bit_wdata,
  // answers and requests
  input wire logic [7:0]          sfr_rdata_q,
  input wire logic                sfr_hit_q,
  input wire logic                bit_rdata_q,
  input wire logic                bit_hit_q,
  input wire logic [NUM_SRC-1:0]  irq_req_q,
  input wire logic                irq_any_q,
  input wire logic [NUM_SRC-1:0]  src_pend_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] wd1_q;
  logic [7:0] wd2_q;
  logic       wr_main;
  logic       wr_exta;
  logic       wr_extb;
  logic       quiet;
  // write data two edges back, the value that reaches the requests
  always_ff @(posedge ref_clk) begin
    wd1_q <= sfr_wdata;
    wd2_q <= wd1_q;
  end
  // qualified byte writes, and a cycle with no register write at all
  assign wr_main = clk_en && sfr_wr && sfr_addr == IE_MAIN_ADDR;
  assign wr_exta = clk_en && sfr_wr && sfr_addr == IE_EXTA_ADDR && sfr_page == EXT_PAGE;
  assign wr_extb = clk_en && sfr_wr && sfr_addr == IE_EXTB_ADDR && sfr_page == EXT_PAGE;
  assign quiet   = clk_en && !sfr_wr && !bit_wr;

  a_any_is_or: assert property (irq_any_q == |irq_req_q)
    else $error("summary request differs from request vector");
  a_req_in_pend: assert property ((irq_req_q & ~src_pend_q) == '0)
    else $error("request without pending source");
  a_hit_needs_rd: assert property (sfr_hit_q |-> $past(sfr_rd))
    else $error("read hit without read strobe");
  a_main_any_page: assert property (clk_en && sfr_rd && sfr_addr == IE_MAIN_ADDR |=> sfr_hit_q)
    else $error("main enable read missed");
  a_ext_off_page: assert property (clk_en && sfr_rd && (sfr_addr == IE_EXTA_ADDR || sfr_addr == IE_EXTB_ADDR)
    && sfr_page != EXT_PAGE |=> !sfr_hit_q && sfr_rdata_q == 8'h00)
    else $error("extended enable answered off its page");
  a_extb_top_zero: assert property (clk_en && sfr_rd && sfr_addr == IE_EXTB_ADDR && sfr_page == EXT_PAGE
    |=> sfr_hit_q && sfr_rdata_q[7:6] == 2'b00)
    else $error("upper bits of second extended enable not zero");
  a_bit_main_hit: assert property (clk_en && bit_rd && bit_addr[7:3] == 5'h15 |=> bit_hit_q)
    else $error("bit read of main enable missed");
  a_gate_closed: assert property ((clk_en && ((sfr_wr && sfr_addr == IE_MAIN_ADDR && !sfr_wdata[7])
    || (!sfr_wr && bit_wr && bit_addr == 8'haf && !bit_wdata))) ##1 quiet |=> irq_req_q == '0)
    else $error("request while global gate closed");
  a_main_mask: assert property (wr_main ##1 quiet |=> (irq_req_q[4:0] & ~wd2_q[4:0]) == 5'h00
    && (!irq_req_q[8] || wd2_q[5]) && (!irq_req_q[11] || wd2_q[6]))
    else $error("main enable bit does not gate its source");
  a_exta_mask: assert property (wr_exta ##1 quiet |=> (irq_req_q[7:5] & ~{wd2_q[1], wd2_q[0], wd2_q[7]}) == 3'h0
    && (irq_req_q[14:12] & ~{wd2_q[5], wd2_q[3], wd2_q[2]}) == 3'h0
    && (irq_req_q[10:9] & ~{wd2_q[4], wd2_q[6]}) == 2'h0)
    else $error("first extended bit does not gate its source");
  a_extb_mask: assert property (wr_extb ##1 quiet |=> (irq_req_q[20:15] & ~wd2_q[5:0]) == 6'h00)
    else $error("second extended bit does not gate its source");

  c_read_hit: cover property (sfr_hit_q);
  c_any_rise: cover property ($rose(irq_any_q));
  c_bit_one: cover property (bit_hit_q && bit_rdata_q);
endmodule : iemb_mask_bank_chk
bind iemb_mask_bank iemb_mask_bank_chk u_chk (.ref_clk, .resetn, .clk_en, .sfr_addr, .sfr_page, .sfr_wr,
  .sfr_rd, .sfr_wdata, .bit_addr, .bit_wr, .bit_rd, .bit_wdata, .sfr_rdata_q, .sfr_hit_q, .bit_rdata_q,
  .bit_hit_q, .irq_req_q, .irq_any_q, .src_pend_q);
`default_nettype wire

// File: iemb_mask_bank_test.sv
`timescale 1ns/100ps
`default_nettype none
module iemb_mask_bank_test;
  import iemb_pkg::*;
  logic ref_clk, resetn, clk_en, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, load;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata_q, m, a, b;
  logic [3:0] sfr_page;
  logic sfr_hit_q, bit_rdata_q, bit_hit_q, irq_any_q;
  logic [NUM_SRC-1:0] irq_req_q, src_pend_q, pend;
  logic [34:0] load_val, flg;
  iemb_flags_t flags;
  int mismatches, check_count, cyc;
  // vector number fed by each raw flag bit, low bit first
  int vec_of[35] = '{17, 6, 6, 7, 7, 7, 7, 7, 7, 7, 7, 12, 12, 12, 20, 19, 18, 13, 10, 14, 9, 9, 9, 8, 11,
                     15, 15, 4, 4, 16, 5, 3, 1, 2, 0};
  iemb_flag_src u_src (.ref_clk(ref_clk), .resetn(resetn), .load(load), .load_val(load_val), .flags_q(flags));
  iemb_mask_bank uut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .bit_addr(bit_addr),
    .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_wdata(bit_wdata), .src_flags(flags), .sfr_rdata_q(sfr_rdata_q),
    .sfr_hit_q(sfr_hit_q), .bit_rdata_q(bit_rdata_q), .bit_hit_q(bit_hit_q), .irq_req_q(irq_req_q),
    .irq_any_q(irq_any_q), .src_pend_q(src_pend_q));
  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, seen);
      mismatches++;
    end
  endtask : chk
  // byte write; the model follows only writes the block should take
  task automatic wr(input logic [7:0] ad, input logic [3:0] pg, input logic [7:0] d);
    @(posedge ref_clk);
    {sfr_addr, sfr_page, sfr_wdata, sfr_wr} <= {ad, pg, d, 1'b1};
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    if (clk_en && ad == 8'ha8) m = d;
    if (clk_en && pg == 4'h0 && ad == 8'h9b) a = d;
    if (clk_en && pg == 4'h0 && ad == 8'h9c) b = d & 8'h3f;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [3:0] pg);
    logic hit;
    hit = ad == 8'ha8 || (pg == 4'h0 && (ad == 8'h9b || ad == 8'h9c));
    @(posedge ref_clk);
    {sfr_addr, sfr_page, sfr_rd} <= {ad, pg, 1'b1};
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1;
    chk("read hit", sfr_hit_q, hit);
    chk("read data", sfr_rdata_q, !hit ? 8'h00 : ad == 8'ha8 ? m : ad == 8'h9b ? a : b);
  endtask : rd
  // bit access to the main enable register, a8..af
  task automatic bop(input logic [2:0] k, input logic w, input logic v);
    @(posedge ref_clk);
    {bit_addr, bit_wr, bit_rd, bit_wdata} <= {5'h15, k, w, !w, v};
    @(posedge ref_clk);
    {bit_wr, bit_rd} <= 2'b00;
    if (w) m[k] = v;
    else begin
      #1;
      chk("bit hit", bit_hit_q, 1'b1);
      chk("bit data", bit_rdata_q, m[k]);
    end
  endtask : bop
  task automatic setf(input logic [34:0] v);
    @(posedge ref_clk);
    {load, load_val} <= {1'b1, v};
    @(posedge ref_clk);
    load <= 1'b0;
    flg = v;
  endtask : setf
  // each request is source flag, own enable and global gate
  task automatic chk_req();
    logic [20:0] en;
    repeat (3) @(posedge ref_clk);
    #1;
    pend = '0;
    for (int j = 0; j < 35; j++) if (flg[j]) pend[vec_of[j]] = 1'b1;
    en = {b[5:0], a[5], a[3], a[2], m[6], a[4], a[6], m[5], a[1], a[0], a[7], m[4:0]} & {21{m[7]}};
    chk("pending", src_pend_q, pend);
    chk("requests", irq_req_q, pend & en);
    chk("any", irq_any_q, |(pend & en));
  endtask : chk_req
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    {resetn, clk_en, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, load} = 8'h40;
    {sfr_addr, sfr_wdata, bit_addr, sfr_page, load_val} = '0;
    {m, a, b, flg} = '0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    // reset values, then pages, masked bits and an unmapped address
    rd(8'ha8, 4'h0);
    rd(8'h9b, 4'h0);
    rd(8'h9c, 4'h0);
    chk_req();
    wr(8'ha8, 4'h3, 8'hff);
    rd(8'ha8, 4'h7);
    wr(8'h9b, 4'h0, 8'hff);
    wr(8'h9c, 4'h0, 8'hff);
    rd(8'h9c, 4'h0);
    wr(8'h9b, 4'h1, 8'h00);
    rd(8'h9b, 4'h2);
    rd(8'h9b, 4'h0);
    rd(8'h9d, 4'h0);
    bop(3'h7, 1'b0, 1'b0);
    bop(3'h4, 1'b1, 1'b0);
    bop(3'h4, 1'b0, 1'b0);
    bop(3'h7, 1'b1, 1'b1);
    bop(3'h4, 1'b1, 1'b1);
    // one flag at a time with every enable set
    for (int j = 0; j < 35; j++) begin
      setf(35'h1 << j);
      chk_req();
    end
    // one enable at a time with every flag set
    setf('1);
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 8; k++) begin
        wr(8'ha8, 4'h0, r == 0 ? 8'h80 | (8'h01 << k) : 8'h80);
        wr(8'h9b, 4'h0, r == 1 ? 8'h01 << k : 8'h00);
        wr(8'h9c, 4'h0, r == 2 ? 8'h01 << k : 8'h00);
        chk_req();
      end
    end
    // flags raised with the gate shut stay pending and request once it opens
    wr(8'ha8, 4'h0, 8'hff);
    wr(8'h9b, 4'h0, 8'hff);
    wr(8'h9c, 4'h0, 8'h3f);
    setf('0);
    bop(3'h7, 1'b1, 1'b0);
    setf(35'h4_0000_0001);
    chk_req();
    bop(3'h7, 1'b1, 1'b1);
    chk_req();
    // frozen clock enable ignores a write
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(8'ha8, 4'h0, 8'h00);
    clk_en <= 1'b1;
    rd(8'ha8, 4'h0);
    complete_run();
  end
endmodule : iemb_mask_bank_test
`default_nettype wire
